// >>> rtl/bridge_parity_error_reporting.sv
// Chosen here: the placing of the registers and register access over APB.
`include "parity_err_consts.svh"
`default_nettype none
module bridge_parity_error_reporting (
  input  wire logic                      clk_in,
  input  wire logic                      reset_in,
  // APB slave.
  input  wire logic                      psel_in,
  input  wire logic                      penable_in,
  input  wire logic                      pwrite_in,
  input  wire logic [`PE_ADDR_W-1:0]     paddr_in,
  input  wire logic [31:0]               pwdata_in,
  output logic      [31:0]               prdata_out,
  output logic                           pready_out,
  output logic                           pslverr_out,
  output logic                           irq_out,
  // Data phase report from the transaction queues.
  input  wire logic                      txn_valid_in,
  input  wire parity_err_pkg::txn_kind_t txn_kind_in,
  input  wire parity_err_pkg::txn_dir_t  txn_dir_in,
  input  wire logic                      upstream_dpe_in,
  input  wire logic                      downstream_dpe_in,
  // Bus pins.
  input  wire logic                      upstream_side_parity_err_n_in,
  output logic                           upstream_side_parity_err_n_out,
  output logic                           upstream_side_parity_err_oe_out,
  input  wire logic                      downstream_side_parity_err_n_in,
  output logic                           downstream_side_parity_err_n_out,
  output logic                           downstream_side_parity_err_oe_out,
  output logic                           upstream_side_system_err_n_out,
  output logic                           upstream_side_system_err_oe_out
);

  // ==========================================================================
  // Register bus
  // ==========================================================================
  logic [`PE_CTRL_W-1:0] ctrl_r;
  logic [`PE_STAT_W-1:0] mask_r;
  logic [`PE_STAT_W-1:0] status;
  logic [`PE_STAT_W-1:0] stat_set;
  logic                  setup;
  logic                  access;
  logic                  hit_ctrl;
  logic                  hit_stat;
  logic                  hit_mask;
  logic                  stat_rd_clr;

  assign setup    = psel_in && !penable_in;
  assign access   = psel_in && penable_in && pready_out;
  assign hit_ctrl = (paddr_in == `PE_OFF_CTRL);
  assign hit_stat = (paddr_in == `PE_OFF_STATUS);
  assign hit_mask = (paddr_in == `PE_OFF_MASK);
  assign stat_rd_clr = access && !pwrite_in && hit_stat;

  // The slave answers in the first access cycle; data is prepared at setup.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end else begin
      pready_out  <= setup;
      pslverr_out <= setup && !(hit_ctrl || hit_stat || hit_mask);
      if (setup && !pwrite_in) begin
        if (hit_ctrl) begin
          prdata_out <= {{(32-`PE_CTRL_W){1'b0}}, ctrl_r};
        end else if (hit_stat) begin
          prdata_out <= {{(32-`PE_STAT_W){1'b0}}, status};
        end else if (hit_mask) begin
          prdata_out <= {{(32-`PE_STAT_W){1'b0}}, mask_r};
        end else begin
          prdata_out <= 32'h0000_0000;
        end
      end else begin
        prdata_out <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ctrl_r <= `PE_CTRL_RESET;
    end else if (access && pwrite_in && hit_ctrl) begin
      ctrl_r <= pwdata_in[`PE_CTRL_W-1:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      mask_r <= `PE_MASK_RESET;
    end else if (access && pwrite_in && hit_mask) begin
      mask_r <= pwdata_in[`PE_STAT_W-1:0];
    end
  end

  // A read clears only the bits that it returned. An event that lands at
  // the setup edge is missed by the read data, so clearing the whole word
  // at the access edge would lose it; it stays set for the next read.
  genvar gi;
  generate
    for (gi = 0; gi < `PE_STAT_W; gi++) begin : g_stat
      sticky_bit #(.RESET_VAL(1'b0)) u_bit (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .set_in   (stat_set[gi]),
        .clear_in (stat_rd_clr && prdata_out[gi]),
        .flag_out (status[gi])
      );
    end
  endgenerate

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(status & mask_r);
    end
  end

  // ==========================================================================
  // Error decode
  // ==========================================================================
  logic up_per;
  logic dn_per;
  logic serr_en;
  logic is_rd;
  logic is_pw;
  logic is_dw;
  logic is_dn;
  logic is_up;
  logic up_perr_seen;
  logic dn_perr_seen;
  logic up_role;
  logic dn_role;
  logic up_perr_hit;
  logic dn_perr_hit;
  logic serr_hit;
  logic mdpd_hit;

  assign up_per  = ctrl_r[`PE_CTRL_UP_PER];
  assign dn_per  = ctrl_r[`PE_CTRL_DN_PER];
  assign serr_en = ctrl_r[`PE_CTRL_SERR_EN];
  assign is_rd   = (txn_kind_in == parity_err_pkg::TXN_READ);
  assign is_pw   = (txn_kind_in == parity_err_pkg::TXN_POSTED_WRITE);
  assign is_dw   = (txn_kind_in == parity_err_pkg::TXN_DELAYED_WRITE);
  assign is_dn   = (txn_dir_in == parity_err_pkg::DIR_DOWNSTREAM);
  assign is_up   = (txn_dir_in == parity_err_pkg::DIR_UPSTREAM);
  assign up_perr_seen = !upstream_side_parity_err_n_in;
  assign dn_perr_seen = !downstream_side_parity_err_n_in;

  // Write target or read initiator on each bus.
  assign up_role = (is_rd && is_up) || ((is_pw || is_dw) && is_dn);
  assign dn_role = (is_rd && is_dn) || ((is_pw || is_dw) && is_up);

  // A delayed write completion forwards the far bus pin back to the
  // initiator bus; the far bus is the target bus of that write.
  assign up_perr_hit = txn_valid_in && up_per &&
                       ((up_role && upstream_dpe_in) ||
                        (is_dw && is_dn && dn_per && dn_perr_seen));
  assign dn_perr_hit = txn_valid_in && dn_per &&
                       ((dn_role && downstream_dpe_in) ||
                        (is_dw && is_up && up_per && up_perr_seen));

  // Only posted writes qualify, so reads and delayed writes never do.
  // A detect on the initiator bus means the bridge caught the error as
  // target itself; that case is reported by the parity pin only.
  assign serr_hit = txn_valid_in && is_pw && serr_en &&
                    up_per && dn_per &&
                    ((is_up && up_perr_seen && !downstream_dpe_in) ||
                     (is_dn && dn_perr_seen && !upstream_dpe_in));

  assign mdpd_hit = txn_valid_in && is_dn && dn_per &&
                    (is_rd || is_pw || is_dw) &&
                    (downstream_dpe_in || dn_perr_seen);

  always_comb begin
    stat_set = `PE_STAT_RESET;
    stat_set[`PE_STAT_DN_MDPD]  = mdpd_hit;
    stat_set[`PE_STAT_SIG_SERR] = serr_hit;
    stat_set[`PE_STAT_UP_PERR]  = up_perr_hit;
    stat_set[`PE_STAT_DN_PERR]  = dn_perr_hit;
  end

  // ==========================================================================
  // Pin drivers
  // ==========================================================================
  // A parity pin is driven low for one clock, then driven high for one
  // clock before release, so the bus does not float from low.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      upstream_side_parity_err_n_out  <= 1'b1;
      upstream_side_parity_err_oe_out <= 1'b0;
    end else begin
      upstream_side_parity_err_n_out  <= !up_perr_hit;
      upstream_side_parity_err_oe_out <= up_perr_hit ||
        (upstream_side_parity_err_oe_out &&
         !upstream_side_parity_err_n_out);
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      downstream_side_parity_err_n_out  <= 1'b1;
      downstream_side_parity_err_oe_out <= 1'b0;
    end else begin
      downstream_side_parity_err_n_out  <= !dn_perr_hit;
      downstream_side_parity_err_oe_out <= dn_perr_hit ||
        (downstream_side_parity_err_oe_out &&
         !downstream_side_parity_err_n_out);
    end
  end

  // System error is open drain: only ever driven low.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      upstream_side_system_err_n_out  <= 1'b1;
      upstream_side_system_err_oe_out <= 1'b0;
    end else begin
      upstream_side_system_err_n_out  <= !serr_hit;
      upstream_side_system_err_oe_out <= serr_hit;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  // Each pin is registered, so its check looks one cycle after the decode.
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  a_up_perr_enable: assert property (!up_per |=>
      upstream_side_parity_err_n_out)
    else $error("primary parity error asserted while disabled");
  a_up_perr_cause: assert property (up_perr_hit |=>
      (!upstream_side_parity_err_n_out &&
       upstream_side_parity_err_oe_out) ##1
      (upstream_side_parity_err_oe_out &&
       upstream_side_parity_err_n_out == !$past(up_perr_hit)))
    else $error("primary parity error pulse wrong");
  a_up_perr_role: assert property ((txn_valid_in && up_per &&
      upstream_dpe_in && !up_role && !is_dw) |=>
      upstream_side_parity_err_n_out)
    else $error("primary parity error driven outside its role");
  a_dn_perr_enable: assert property (!dn_per |=>
      downstream_side_parity_err_n_out)
    else $error("secondary parity error asserted while disabled");
  a_dn_perr_cause: assert property ((txn_valid_in && dn_per &&
      dn_role && downstream_dpe_in) |=>
      (!downstream_side_parity_err_n_out &&
       downstream_side_parity_err_oe_out) ##1
      (downstream_side_parity_err_oe_out &&
       downstream_side_parity_err_n_out == !$past(dn_perr_hit)))
    else $error("secondary parity error missing");
  a_dn_perr_role: assert property ((txn_valid_in && is_pw &&
      is_dn && !up_perr_seen) |=> downstream_side_parity_err_n_out)
    else $error("secondary parity error driven outside its role");
  a_perr_idle_high: assert property (!upstream_side_parity_err_oe_out
      |-> upstream_side_parity_err_n_out)
    else $error("primary parity error low while released");
  a_serr_posted: assert property ((txn_valid_in && !is_pw) |=>
      upstream_side_system_err_n_out)
    else $error("system error for a non posted transaction");
  a_serr_gate: assert property (!upstream_side_system_err_n_out |->
      $past(up_per && dn_per && serr_en))
    else $error("system error asserted with an enable clear");
  a_serr_self: assert property ((txn_valid_in && is_pw && is_up &&
      downstream_dpe_in) |=> upstream_side_system_err_n_out)
    else $error("system error for a self detected error");
  a_serr_status: assert property (serr_hit |=>
      (!upstream_side_system_err_n_out && status[`PE_STAT_SIG_SERR]))
    else $error("system error without status bit");
  a_mdpd_set: assert property (mdpd_hit |=>
      status[`PE_STAT_DN_MDPD])
    else $error("master data parity bit not set");
  a_mdpd_up: assert property ($rose(status[`PE_STAT_DN_MDPD]) |->
      $past(txn_valid_in && is_dn && dn_per))
    else $error("master data parity bit set without cause");
  a_dn_idle_high: assert property (!downstream_side_parity_err_oe_out
      |-> downstream_side_parity_err_n_out)
    else $error("secondary parity error low while released");
  a_up_perr_fwd: assert property ((txn_valid_in && is_dw && is_dn &&
      up_per && dn_per && dn_perr_seen) |=>
      !upstream_side_parity_err_n_out)
    else $error("secondary parity error not forwarded");
  a_dn_perr_fwd: assert property ((txn_valid_in && is_dw && is_up &&
      up_per && dn_per && up_perr_seen) |=>
      !downstream_side_parity_err_n_out)
    else $error("primary parity error not forwarded");
  a_serr_open_drain: assert property (upstream_side_system_err_oe_out
      == !upstream_side_system_err_n_out)
    else $error("system error driven high or released low");
  a_rdclr_keep: assert property (stat_rd_clr |=>
      (($past(status) & ~$past(prdata_out[`PE_STAT_W-1:0]) & ~status)
       == '0))
    else $error("status bit lost by a racing read");
  a_ready_timing: assert property ((psel_in && !penable_in) |=>
      pready_out)
    else $error("ready missing in the first access cycle");

  c_up_perr: cover property (!upstream_side_parity_err_n_out);
  c_dn_perr: cover property (!downstream_side_parity_err_n_out);
  c_serr:    cover property (!upstream_side_system_err_n_out);
  c_irq:     cover property (irq_out ##1 stat_rd_clr);
  c_dw_fwd:  cover property (txn_valid_in && is_dw && dn_perr_hit);

endmodule
`default_nettype wire

// >>> rtl/parity_err_consts.svh
// Notes on behaviour
// - Master parity bit sets on a downstream secondary error, sec enable 1.
// - Primary parity out drives only as write target or read initiator.
// - Primary parity out stays inactive unless the primary enable is 1.
// - Primary parity out asserts on own error or secondary pin in a down DW.
// - Secondary parity out drives only as write target or read initiator.
// - Secondary parity out stays inactive unless the secondary enable is 1.
// - Secondary parity out asserts on own error or primary pin in an up DW.
// - Parity outputs are active low and stay at 1 in every unselected case.
// - System error asserts on a parity pin seen on a posted write target bus.
// - Posted write system error needs that the bridge did not detect it.
// - Both parity response enables must be 1 for posted write system error.
// - The system error enable must be 1 before system error is asserted.
// - Reads and delayed writes never cause system error for data parity.
// - Each system error assertion also sets the signaled system error bit.
`ifndef PARITY_ERR_CONSTS_SVH
`define PARITY_ERR_CONSTS_SVH

`define PE_ADDR_W        8
`define PE_OFF_CTRL      8'h00
`define PE_OFF_STATUS    8'h04
`define PE_OFF_MASK      8'h08

`define PE_CTRL_W        3
`define PE_CTRL_UP_PER   0
`define PE_CTRL_DN_PER   1
`define PE_CTRL_SERR_EN  2
`define PE_CTRL_RESET    3'h0

`define PE_STAT_W        4
`define PE_STAT_DN_MDPD  0
`define PE_STAT_SIG_SERR 1
`define PE_STAT_UP_PERR  2
`define PE_STAT_DN_PERR  3
`define PE_STAT_RESET    4'h0
`define PE_MASK_RESET    4'h0

`endif

// >>> rtl/parity_err_pkg.sv
`default_nettype none
package parity_err_pkg;
  typedef enum logic [1:0] {
    TXN_READ,
    TXN_POSTED_WRITE,
    TXN_DELAYED_WRITE,
    TXN_OTHER
  } txn_kind_t;

  typedef enum logic {
    DIR_DOWNSTREAM,
    DIR_UPSTREAM
  } txn_dir_t;
endpackage
`default_nettype wire

// >>> rtl/sticky_bit.sv
`default_nettype none
// A hardware set in the same cycle as a clear wins, so no event is lost.
module sticky_bit #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic clk_in,
  input  wire logic reset_in,
  input  wire logic set_in,
  input  wire logic clear_in,
  output logic      flag_out
);
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      flag_out <= RESET_VAL;
    end else if (set_in) begin
      flag_out <= 1'b1;
    end else if (clear_in) begin
      flag_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> verification/pci_far_side.sv
`default_nettype none
module pci_far_side (
  input  wire logic up_n_in,
  input  wire logic up_oe_in,
  input  wire logic dn_n_in,
  input  wire logic dn_oe_in,
  input  wire logic far_up_in,
  input  wire logic far_dn_in,
  output logic      up_pin_out,
  output logic      dn_pin_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Both lines have pull-ups, so a released line reads high.
  assign up_pin_out = !((up_oe_in & !up_n_in) | far_up_in);
  assign dn_pin_out = !((dn_oe_in & !dn_n_in) | far_dn_in);
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
`include "parity_err_consts.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [`PE_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, irq, er, tv = 0, up_dpe = 0, dn_dpe = 0;
  logic up_pin, dn_pin, up_n, up_oe, dn_n, dn_oe, se_n, se_oe;
  logic far_p = 0, far_s = 0;
  logic [3:0] msk;
  parity_err_pkg::txn_kind_t tk = parity_err_pkg::TXN_OTHER;
  parity_err_pkg::txn_dir_t td = parity_err_pkg::DIR_DOWNSTREAM;
  int failures = 0, comparisons = 0;
  always #12.5 clk = !clk;
  bridge_parity_error_reporting dut_u (
    .clk_in(clk), .reset_in(rst), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .irq_out(irq), .txn_valid_in(tv), .txn_kind_in(tk), .txn_dir_in(td),
    .upstream_dpe_in(up_dpe), .downstream_dpe_in(dn_dpe),
    .upstream_side_parity_err_n_in(up_pin),
    .upstream_side_parity_err_n_out(up_n),
    .upstream_side_parity_err_oe_out(up_oe),
    .downstream_side_parity_err_n_in(dn_pin),
    .downstream_side_parity_err_n_out(dn_n),
    .downstream_side_parity_err_oe_out(dn_oe),
    .upstream_side_system_err_n_out(se_n),
    .upstream_side_system_err_oe_out(se_oe));
  pci_far_side far_u (
    .up_n_in(up_n), .up_oe_in(up_oe), .dn_n_in(dn_n), .dn_oe_in(dn_oe),
    .far_up_in(far_p), .far_dn_in(far_s),
    .up_pin_out(up_pin), .dn_pin_out(dn_pin));
  // ==========================================================
  // Reporting
  task automatic wrap_up;
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // ==========================================================
  // Register access
  task automatic apb(input logic w, input logic [`PE_ADDR_W-1:0] a,
                     input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) check(33'h0, 33'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // ==========================================================
  // One data phase report. The detect inputs follow every error on their
  // bus, so role gating is exercised; the far pin carries the error where
  // the bridge is not the one that checks parity.
  task automatic ev(input logic [2:0] c, input logic [1:0] k,
                    input logic d, input logic [1:0] e);
    logic rp, rs, pw, dw, rdk, ep, es, ue, de, se, s0;
    rdk = (k == 2'h0);
    pw = (k == 2'h1);
    dw = (k == 2'h2);
    ep = e[0];
    es = e[1];
    rp = (rdk & d) | ((pw | dw) & !d);
    rs = (rdk & !d) | ((pw | dw) & d);
    ue = c[0] & ((ep & rp) | (dw & !d & c[1] & es));
    de = c[1] & ((es & rs) | (dw & d & c[0] & ep));
    se = pw & (&c) & ((d & ep & !es) | (!d & es & !ep));
    s0 = !d & c[1] & es & (k != 2'h3);
    @(posedge clk);
    tv <= 1'b1;
    tk <= parity_err_pkg::txn_kind_t'(k);
    td <= parity_err_pkg::txn_dir_t'(d);
    up_dpe <= ep;
    dn_dpe <= es;
    far_p <= ep & !rp;
    far_s <= es & !rs;
    @(posedge clk);
    {tv, up_dpe, dn_dpe, far_p, far_s} <= 5'h00;
    @(negedge clk);
    check(33'(up_n), 33'(!ue));
    check(33'(dn_n), 33'(!de));
    check(33'(se_n), 33'(!se));
    check(33'(se_oe), 33'(se));
    @(negedge clk);
    check(33'({up_oe, up_n, dn_oe, dn_n}), 33'({ue, 1'b1, de, 1'b1}));
    check(33'(irq), 33'(|({de, ue, se, s0} & msk)));
    apb(1'b0, `PE_OFF_STATUS, '0);
    check(33'(rd), 33'({28'h0, de, ue, se, s0}));
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (10000) @(posedge clk);
    failures++;
    wrap_up();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check(33'({up_n, up_oe, dn_n, dn_oe, se_n, se_oe}), 33'h2a);
    check(33'({pready, pslverr, irq}), 33'h0);
    check(33'(prdata), 33'h0);
    apb(1'b0, `PE_OFF_CTRL, '0);
    check({er, rd}, {1'b0, 29'h0, `PE_CTRL_RESET});
    apb(1'b0, `PE_OFF_MASK, '0);
    check({er, rd}, {1'b0, 28'h0, `PE_MASK_RESET});
    apb(1'b1, 8'h0c, 32'hffffffff);
    check({er, rd}, {1'b1, 32'h0});
    apb(1'b1, `PE_OFF_CTRL, 32'hffffffff);
    apb(1'b0, `PE_OFF_CTRL, '0);
    check(33'(rd), 33'h7);
    msk = 4'h2;
    apb(1'b1, `PE_OFF_MASK, {28'h0, msk});
    for (int i = 0; i < 192; i++) begin
      if (i % 24 == 0) apb(1'b1, `PE_OFF_CTRL, 32'(i / 24));
      ev(3'(i / 24), 2'(i % 4), 1'(i / 4 % 2), 2'(i / 8 % 3 + 1));
    end
    msk = 4'h0;
    apb(1'b1, `PE_OFF_MASK, '0);
    ev(3'h7, 2'h1, 1'b0, 2'h2);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, `PE_OFF_CTRL, '0);
    check({er, rd}, {1'b0, 29'h0, `PE_CTRL_RESET});
    wrap_up();
  end
endmodule
`default_nettype wire
